// ---- include/facs_defines.svh ----
// Constants for the fragment acknowledgment and channel switch block.
`ifndef FACS_DEFINES_SVH
`define FACS_DEFINES_SVH

`define FACS_FRAG_CNT        32
`define FACS_FCS_W           16
`define FACS_CHAN_W          8
`define FACS_PHY_W           8
`define FACS_FEEDBACK_W      8
`define FACS_ADDR_W          16
`define FACS_PAN_W           16
`define FACS_BCAST_ADDR      16'hFFFF
`define FACS_BCAST_PAN       16'hFFFF
`define FACS_DIR_TX          8'h00
`define FACS_DIR_RX          8'h01
`define FACS_HOP_NONE        8'h00
`define FACS_HOP_REQ         8'h01
`define FACS_CMD_CHAN        1'b0
`define FACS_CMD_PHY         1'b1
`define FACS_ACK_WAIT_CYC    16'h0100
`define FACS_REVERT_DEFAULT  32'h0001_0000

`endif

// ---- include/facs_pkg.sv ----
// Types shared by the fragment acknowledgment and channel switch block.
package facs_pkg;
	typedef enum logic [2:0] {
		FACS_SW_IDLE    = 3'b000,
		FACS_SW_HOLD    = 3'b001,
		FACS_SW_SEND    = 3'b011,
		FACS_SW_WAITACK = 3'b010,
		FACS_SW_ACTIVE  = 3'b110,
		FACS_SW_REVERT  = 3'b111
	} facs_sw_state_t;

	typedef enum logic [1:0] {
		FACS_ACK_IDLE  = 2'b00,
		FACS_ACK_WAIT  = 2'b01,
		FACS_ACK_EXT   = 2'b11
	} facs_ack_state_t;
endpackage : facs_pkg

// ---- logic/facs_status_collect.sv ----
// Per-fragment reception status bitmap for the fragment status element.
`timescale 1ns/1ps
`include "facs_defines.svh"

module facs_status_collect (
	input  wire logic                       clk_sys,
	input  wire logic                       reset_n,
	input  wire logic                       seq_start,
	input  wire logic                       frag_ok,
	input  wire logic [4:0]                 frag_num,
	output logic      [`FACS_FRAG_CNT-1:0]  status_ff
);
	// One flag per fragment; a new sequence clears all, a reception in the
	// same cycle still sets its own flag.
	genvar g;
	generate
		for (g = 0; g < `FACS_FRAG_CNT; g++) begin : g_flag
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					status_ff[g] <= 1'b0;
				end else if (frag_ok && frag_num == 5'(g)) begin
					status_ff[g] <= 1'b1;
				end else if (seq_start) begin
					status_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : facs_status_collect

// ---- logic/facs_revert_timer.sv ----
// Down-counter that expires after the switch revert timeout.
`timescale 1ns/1ps
`include "facs_defines.svh"

module facs_revert_timer #(
	parameter logic [31:0] TIMEOUT_CYC = `FACS_REVERT_DEFAULT
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic        stop,
	output logic             expired_ff
);
	logic [31:0] count_ff;
	logic        run_ff;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_ff <= 32'h0000_0000;
			run_ff   <= 1'b0;
		end else if (start) begin
			count_ff <= TIMEOUT_CYC;
			run_ff   <= 1'b1;
		end else if (stop) begin
			run_ff   <= 1'b0;
		end else if (run_ff && count_ff <= 32'h0000_0001) begin
			run_ff   <= 1'b0;
		end else if (run_ff) begin
			count_ff <= count_ff - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			expired_ff <= 1'b0;
		end else begin
			expired_ff <= run_ff && !start && !stop && count_ff <= 32'h0000_0001;
		end
	end
endmodule : facs_revert_timer

// ---- logic/facs_top.sv ----
// Final fragment acknowledgment and channel switch handshake of the recipient MAC.
`timescale 1ns/1ps
`include "facs_defines.svh"

module facs_top #(
	parameter logic [31:0] REVERT_CYC = `FACS_REVERT_DEFAULT
) (
	input  wire logic                          clk_sys,
	input  wire logic                          reset_n,
	input  wire logic                          extended_ack_enable,
	input  wire logic                          seq_start,
	input  wire logic                          frag_ok,
	input  wire logic [4:0]                    frag_num,
	input  wire logic                          frag_final,
	input  wire logic                          frame_ack_req,
	input  wire logic                          reassembly_done,
	input  wire logic                          filter_enable,
	input  wire logic                          filter_done,
	input  wire logic [`FACS_FCS_W-1:0]        final_fcs,
	input  wire logic                          interval_end,
	input  wire logic                          extended_ack_service_request,
	input  wire logic [`FACS_FEEDBACK_W-1:0]   ext_feedback,
	input  wire logic [`FACS_FRAG_CNT-1:0]     ext_status,
	input  wire logic                          channel_change_service,
	input  wire logic                          change_is_phy,
	input  wire logic [`FACS_CHAN_W-1:0]       new_channel,
	input  wire logic [`FACS_PHY_W-1:0]        new_phy,
	input  wire logic [`FACS_ADDR_W-1:0]       originator_addr,
	input  wire logic [`FACS_PAN_W-1:0]        originator_pan,
	input  wire logic                          cmd_acked,
	input  wire logic                          link_ok,
	input  wire logic                          guaranteed_slot_rx,
	input  wire logic                          hop_sequence_wanted,
	output logic                               ack_send_ff,
	output logic                               ack_pending_ff,
	output logic                               ack_has_status_ff,
	output logic [`FACS_FRAG_CNT-1:0]          ack_status_ff,
	output logic [`FACS_FCS_W-1:0]             ack_fcs_ff,
	output logic [`FACS_FEEDBACK_W-1:0]        ack_feedback_ff,
	output logic                               frame_up_ff,
	output logic [`FACS_FRAG_CNT-1:0]          frame_up_status_ff,
	output logic                               channel_switch_command_ff,
	output logic                               ack_request_bit_ff,
	output logic                               cmd_is_phy_ff,
	output logic [`FACS_CHAN_W-1:0]            cmd_channel_ff,
	output logic [`FACS_PHY_W-1:0]             cmd_phy_ff,
	output logic [`FACS_ADDR_W-1:0]            cmd_dest_ff,
	output logic [`FACS_PAN_W-1:0]             cmd_pan_ff,
	output logic [`FACS_CHAN_W-1:0]            cur_channel_ff,
	output logic [`FACS_PHY_W-1:0]             cur_phy_ff,
	output logic                               switch_failed_ff,
	output logic [7:0]                         guaranteed_slot_allocation_ff,
	output logic [7:0]                         hop_sequence_request_ff
);
	import facs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Address check used by both the send decision and the assertion.

	function automatic logic is_directed(input logic [`FACS_ADDR_W-1:0] a,
	                                     input logic [`FACS_PAN_W-1:0] p);
		is_directed = (a != `FACS_BCAST_ADDR) && (p != `FACS_BCAST_PAN);
	endfunction : is_directed

	////////////////////////////////////////////////////////////////////////////////
	// Fragment status and revert timer.

	logic [`FACS_FRAG_CNT-1:0] status_w;
	logic                      revert_w;
	logic                      timer_start;
	logic                      timer_stop;

	facs_status_collect u_status (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.seq_start (seq_start),
		.frag_ok   (frag_ok),
		.frag_num  (frag_num),
		.status_ff (status_w)
	);

	facs_revert_timer #(.TIMEOUT_CYC(REVERT_CYC)) u_timer (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.start      (timer_start),
		.stop       (timer_stop),
		.expired_ff (revert_w)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Final frame acknowledgment.

	facs_ack_state_t ack_state_ff;
	logic            filt_ok;

	assign filt_ok = !filter_enable || filter_done;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ack_state_ff <= FACS_ACK_IDLE;
		end else begin
			case (ack_state_ff)
				FACS_ACK_IDLE: begin
					if (frag_final && frame_ack_req && !extended_ack_enable) begin
						ack_state_ff <= FACS_ACK_WAIT;
					end else if (frag_final && frame_ack_req) begin
						ack_state_ff <= FACS_ACK_EXT;
					end
				end
				FACS_ACK_WAIT: begin
					if (reassembly_done && filt_ok) begin
						ack_state_ff <= FACS_ACK_IDLE;
					end
				end
				FACS_ACK_EXT: begin
					if (extended_ack_service_request) begin
						ack_state_ff <= FACS_ACK_IDLE;
					end
				end
				default: ack_state_ff <= FACS_ACK_IDLE;
			endcase
		end
	end

	logic [1:0] ack_kind;
	logic       pend_ack;
	facs_sw_state_t sw_state_ff;

	// Kind 1: normal final ack; 2: extended final ack; pending acks keep kind 0 and set pend_ack.
	always_comb begin
		ack_kind = 2'h0;
		pend_ack = 1'b0;
		if (ack_state_ff == FACS_ACK_WAIT && reassembly_done && filt_ok) begin
			ack_kind = 2'h1;
		end else if (ack_state_ff == FACS_ACK_EXT && extended_ack_service_request) begin
			ack_kind = 2'h2;
		end else if (ack_state_ff == FACS_ACK_IDLE && frag_final && frame_ack_req &&
		             extended_ack_enable) begin
			pend_ack = 1'b1;
		end else if (sw_state_ff == FACS_SW_HOLD && interval_end) begin
			pend_ack = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ack_send_ff       <= 1'b0;
			ack_pending_ff    <= 1'b0;
			ack_has_status_ff <= 1'b0;
			ack_status_ff     <= '0;
			ack_fcs_ff        <= '0;
			ack_feedback_ff   <= '0;
		end else begin
			ack_send_ff       <= (ack_kind != 2'h0) || pend_ack;
			ack_pending_ff    <= pend_ack;
			ack_has_status_ff <= ack_kind != 2'h0;
			if (ack_kind == 2'h1) begin
				ack_status_ff <= status_w;
				ack_fcs_ff    <= final_fcs;
			end else if (ack_kind == 2'h2) begin
				ack_status_ff   <= ext_status;
				ack_fcs_ff      <= final_fcs;
				ack_feedback_ff <= ext_feedback;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			frame_up_ff        <= 1'b0;
			frame_up_status_ff <= '0;
		end else begin
			frame_up_ff <= ack_state_ff == FACS_ACK_IDLE && frag_final && frame_ack_req &&
			               extended_ack_enable;
			if (ack_state_ff == FACS_ACK_IDLE && frag_final) begin
				frame_up_status_ff <= status_w;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel switch handshake.

	logic [`FACS_CHAN_W-1:0] prev_channel_ff;
	logic [`FACS_PHY_W-1:0]  prev_phy_ff;
	logic [`FACS_CHAN_W-1:0] req_channel_ff;
	logic [`FACS_PHY_W-1:0]  req_phy_ff;
	logic                    req_phy_ff_sel;
	logic [15:0]             wait_ff;
	logic                    send_now;
	logic                    ack_timeout;

	assign send_now    = sw_state_ff == FACS_SW_SEND &&
	                     is_directed(originator_addr, originator_pan);
	assign ack_timeout = wait_ff == 16'h0000;
	assign timer_start = sw_state_ff == FACS_SW_SEND && send_now;
	assign timer_stop  = sw_state_ff == FACS_SW_ACTIVE && link_ok;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sw_state_ff <= FACS_SW_IDLE;
			wait_ff     <= 16'h0000;
		end else begin
			case (sw_state_ff)
				FACS_SW_IDLE: begin
					if (channel_change_service) begin
						sw_state_ff <= FACS_SW_HOLD;
					end
				end
				FACS_SW_HOLD: sw_state_ff <= FACS_SW_SEND;
				FACS_SW_SEND: begin
					if (send_now) begin
						sw_state_ff <= FACS_SW_WAITACK;
						wait_ff     <= `FACS_ACK_WAIT_CYC;
					end else begin
						sw_state_ff <= FACS_SW_IDLE;
					end
				end
				FACS_SW_WAITACK: begin
					if (cmd_acked) begin
						sw_state_ff <= FACS_SW_ACTIVE;
					end else if (ack_timeout) begin
						// The revert timer may already have expired during the ack wait,
						// so an aborted switch reverts at once instead of waiting on it.
						sw_state_ff <= FACS_SW_REVERT;
					end else begin
						wait_ff <= wait_ff - 16'h0001;
					end
				end
				FACS_SW_ACTIVE: begin
					if (link_ok) begin
						sw_state_ff <= FACS_SW_IDLE;
					end else if (revert_w) begin
						sw_state_ff <= FACS_SW_REVERT;
					end
				end
				FACS_SW_REVERT: sw_state_ff <= FACS_SW_IDLE;
				default: sw_state_ff <= FACS_SW_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			req_channel_ff <= '0;
			req_phy_ff     <= '0;
			req_phy_ff_sel <= 1'b0;
		end else if (sw_state_ff == FACS_SW_IDLE && channel_change_service) begin
			req_channel_ff <= new_channel;
			req_phy_ff     <= new_phy;
			req_phy_ff_sel <= change_is_phy;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			channel_switch_command_ff <= 1'b0;
			ack_request_bit_ff        <= 1'b0;
			cmd_is_phy_ff             <= 1'b0;
			cmd_channel_ff            <= '0;
			cmd_phy_ff                <= '0;
			cmd_dest_ff               <= '0;
			cmd_pan_ff                <= '0;
		end else begin
			channel_switch_command_ff <= send_now;
			ack_request_bit_ff        <= send_now;
			if (send_now) begin
				cmd_is_phy_ff  <= req_phy_ff_sel;
				cmd_channel_ff <= req_channel_ff;
				cmd_phy_ff     <= req_phy_ff;
				cmd_dest_ff    <= originator_addr;
				cmd_pan_ff     <= originator_pan;
			end
		end
	end

	// Configuration changes only on an acknowledged command; the stored copy
	// is restored when the link is not re-established in time.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cur_channel_ff   <= '0;
			cur_phy_ff       <= '0;
			prev_channel_ff  <= '0;
			prev_phy_ff      <= '0;
			switch_failed_ff <= 1'b0;
		end else begin
			if (timer_start) begin
				prev_channel_ff <= cur_channel_ff;
				prev_phy_ff     <= cur_phy_ff;
			end
			if (sw_state_ff == FACS_SW_WAITACK && cmd_acked) begin
				if (req_phy_ff_sel == `FACS_CMD_PHY) begin
					cur_phy_ff <= req_phy_ff;
				end else begin
					cur_channel_ff <= req_channel_ff;
				end
			end else if (sw_state_ff == FACS_SW_REVERT) begin
				cur_channel_ff <= prev_channel_ff;
				cur_phy_ff     <= prev_phy_ff;
			end
			switch_failed_ff <= sw_state_ff == FACS_SW_WAITACK && !cmd_acked &&
			                    ack_timeout;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Association parameter encodings.

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			guaranteed_slot_allocation_ff <= `FACS_DIR_TX;
			hop_sequence_request_ff       <= `FACS_HOP_NONE;
		end else begin
			guaranteed_slot_allocation_ff <= guaranteed_slot_rx ? `FACS_DIR_RX
			                                                    : `FACS_DIR_TX;
			hop_sequence_request_ff <= hop_sequence_wanted ? `FACS_HOP_REQ
			                                               : `FACS_HOP_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_cmd_out;
		channel_switch_command_ff && ack_request_bit_ff;
	endsequence

	a_cmd_ack_req: assert property (@(posedge clk_sys) disable iff (!reset_n)
		channel_switch_command_ff |-> s_cmd_out)
		else $error("Switch command sent without ack request bit.");
	a_cmd_directed: assert property (@(posedge clk_sys) disable iff (!reset_n)
		channel_switch_command_ff |-> is_directed(cmd_dest_ff, cmd_pan_ff))
		else $error("Switch command sent to a broadcast address.");
	a_cmd_dest_orig: assert property (@(posedge clk_sys) disable iff (!reset_n)
		send_now |=> cmd_dest_ff == $past(originator_addr))
		else $error("Switch command not addressed to the originator.");
	a_noack_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(sw_state_ff == FACS_SW_WAITACK && !cmd_acked) |=> $stable(cur_channel_ff))
		else $error("Channel changed without acknowledgment.");
	a_ack_after_reasm: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(ack_kind == 2'h1) |-> (reassembly_done && filt_ok))
		else $error("Final ack before reassembly and filtering.");
	a_ext_pending: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(ack_state_ff == FACS_ACK_IDLE && frag_final && frame_ack_req && extended_ack_enable)
		|=> ack_send_ff && ack_pending_ff && frame_up_ff && !ack_has_status_ff)
		else $error("Extended mode final fragment not answered with pending ack.");
	a_ext_feedback: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(ack_state_ff == FACS_ACK_EXT && extended_ack_service_request)
		|=> ack_has_status_ff && ack_feedback_ff == $past(ext_feedback))
		else $error("Extended ack lacks supplied feedback.");
	a_status_fill: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(ack_kind == 2'h1) |=> ack_status_ff == $past(status_w) && ack_fcs_ff == $past(final_fcs))
		else $error("Status element not filled from fragment flags.");
	a_revert_restore: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(sw_state_ff == FACS_SW_REVERT) |=> cur_channel_ff == $past(prev_channel_ff))
		else $error("Revert did not restore the prior channel.");
endmodule : facs_top

// ---- test/facs_peer_model.sv ----
// Peer originator model that answers channel switch commands.
`timescale 1ns/1ps

module facs_peer_model (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       cmd_seen,
	input  wire logic       ack_req_seen,
	input  wire logic [1:0] ack_mode,
	input  wire logic       link_mode,
	output logic            cmd_acked,
	output logic            link_ok
);
	int wait_ack;
	int wait_link;

	////////////////////////////////////////////////////////////////////////////////
	// Mode 0 stays silent, mode 1 answers three cycles after the command, mode 2 answers late but inside
	// the ack window, so the bench can exercise a missing and a slow acknowledgment.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cmd_acked <= 1'b0;
			link_ok   <= 1'b0;
			wait_ack  <= 0;
			wait_link <= 0;
		end else begin
			cmd_acked <= 1'b0;
			link_ok   <= 1'b0;
			if (cmd_seen && ack_req_seen && ack_mode != 2'h0) begin
				wait_ack <= (ack_mode == 2'h1) ? 2 : 12;
			end else if (wait_ack == 1) begin
				cmd_acked <= 1'b1;
				wait_link <= link_mode ? 4 : 0;
				wait_ack  <= 0;
			end else if (wait_ack > 1) begin
				wait_ack <= wait_ack - 1;
			end
			if (wait_link == 1) begin
				link_ok <= 1'b1;
			end
			if (wait_link > 0) begin
				wait_link <= wait_link - 1;
			end
		end
	end
endmodule : facs_peer_model

// ---- test/fragment_ack_channel_switch_tb_top.sv ----
// Self-checking bench for the fragment acknowledgment and channel switch block.
`timescale 1ns/1ps
`include "facs_defines.svh"

module fragment_ack_channel_switch_tb_top;
	localparam logic [31:0] REV = 32'h0000_0014;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        extended_ack_enable, seq_start, frag_ok, frag_final, frame_ack_req;
	logic        reassembly_done, filter_enable, filter_done, interval_end;
	logic        extended_ack_service_request, channel_change_service, change_is_phy;
	logic        cmd_acked, link_ok, guaranteed_slot_rx, hop_sequence_wanted, link_mode;
	logic [1:0]  ack_mode;
	logic [4:0]  frag_num;
	logic [15:0] final_fcs, originator_addr, originator_pan, ack_fcs_ff, cmd_dest_ff, cmd_pan_ff;
	logic [7:0]  ext_feedback, new_channel, new_phy, ack_feedback_ff, cmd_channel_ff, cmd_phy_ff;
	logic [7:0]  cur_channel_ff, cur_phy_ff, guaranteed_slot_allocation_ff, hop_sequence_request_ff;
	logic [31:0] ext_status, ack_status_ff, frame_up_status_ff, exp_map;
	logic        ack_send_ff, ack_pending_ff, ack_has_status_ff, frame_up_ff, switch_failed_ff;
	logic        channel_switch_command_ff, ack_request_bit_ff, cmd_is_phy_ff;
	logic [7:0]  exp_ch, exp_ph;
	wire  [5:0]  ev;
	int          miscompares = 0;
	int          n_tests = 0;

	assign ev = {switch_failed_ff, channel_switch_command_ff, frame_up_ff, ack_pending_ff,
		ack_has_status_ff, ack_send_ff};

	always #2.5 clk_sys = ~clk_sys;

	facs_top #(.REVERT_CYC(REV)) facs_top_i (
		.clk_sys                       (clk_sys),
		.reset_n                       (reset_n),
		.extended_ack_enable           (extended_ack_enable),
		.seq_start                     (seq_start),
		.frag_ok                       (frag_ok),
		.frag_num                      (frag_num),
		.frag_final                    (frag_final),
		.frame_ack_req                 (frame_ack_req),
		.reassembly_done               (reassembly_done),
		.filter_enable                 (filter_enable),
		.filter_done                   (filter_done),
		.final_fcs                     (final_fcs),
		.interval_end                  (interval_end),
		.extended_ack_service_request  (extended_ack_service_request),
		.ext_feedback                  (ext_feedback),
		.ext_status                    (ext_status),
		.channel_change_service        (channel_change_service),
		.change_is_phy                 (change_is_phy),
		.new_channel                   (new_channel),
		.new_phy                       (new_phy),
		.originator_addr               (originator_addr),
		.originator_pan                (originator_pan),
		.cmd_acked                     (cmd_acked),
		.link_ok                       (link_ok),
		.guaranteed_slot_rx            (guaranteed_slot_rx),
		.hop_sequence_wanted           (hop_sequence_wanted),
		.ack_send_ff                   (ack_send_ff),
		.ack_pending_ff                (ack_pending_ff),
		.ack_has_status_ff             (ack_has_status_ff),
		.ack_status_ff                 (ack_status_ff),
		.ack_fcs_ff                    (ack_fcs_ff),
		.ack_feedback_ff               (ack_feedback_ff),
		.frame_up_ff                   (frame_up_ff),
		.frame_up_status_ff            (frame_up_status_ff),
		.channel_switch_command_ff     (channel_switch_command_ff),
		.ack_request_bit_ff            (ack_request_bit_ff),
		.cmd_is_phy_ff                 (cmd_is_phy_ff),
		.cmd_channel_ff                (cmd_channel_ff),
		.cmd_phy_ff                    (cmd_phy_ff),
		.cmd_dest_ff                   (cmd_dest_ff),
		.cmd_pan_ff                    (cmd_pan_ff),
		.cur_channel_ff                (cur_channel_ff),
		.cur_phy_ff                    (cur_phy_ff),
		.switch_failed_ff              (switch_failed_ff),
		.guaranteed_slot_allocation_ff (guaranteed_slot_allocation_ff),
		.hop_sequence_request_ff       (hop_sequence_request_ff)
	);

	facs_peer_model facs_peer_model_i (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.cmd_seen     (channel_switch_command_ff),
		.ack_req_seen (ack_request_bit_ff),
		.ack_mode     (ack_mode),
		.link_mode    (link_mode),
		.cmd_acked    (cmd_acked),
		.link_ok      (link_ok)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] code_of(input logic on);
		return on ? 8'h01 : 8'h00;
	endfunction : code_of

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Returns just after the edge where event k is seen high, or after lim edges.
	task automatic wait_ev(input int k, input int lim, output logic hit);
		hit = 1'b0;
		#1;
		for (int i = 0; i < lim && !hit; i++) begin
			if (ev[k] === 1'b1) hit = 1'b1;
			else begin
				@(posedge clk_sys);
				#1;
			end
		end
	endtask : wait_ev

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	task automatic run_ack(input logic ext);
		logic        b;
		logic [15:0] fcs;
		logic [7:0]  fb;
		logic [31:0] st;
		exp_map = '0;
		fcs = 16'($urandom);
		@(posedge clk_sys);
		extended_ack_enable <= ext;
		seq_start <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			b = ($urandom_range(0, 3) != 0) || i == 0 || i == 31;
			exp_map[i] = b;
			@(posedge clk_sys);
			seq_start <= 1'b0;
			frag_num <= 5'(i);
			frag_ok <= b;
		end
		@(posedge clk_sys);
		frag_ok <= 1'b0;
		final_fcs <= fcs;
		frag_final <= 1'b1;
		frame_ack_req <= 1'b1;
		filter_enable <= !ext;
		@(posedge clk_sys);
		frag_final <= 1'b0;
		if (ext) begin
			wait_ev(0, 3, b);
			check(b, 1);
			check({ack_pending_ff, frame_up_ff}, 2'b11);
			check(frame_up_status_ff, exp_map);
			fb = 8'($urandom);
			st = $urandom;
			@(posedge clk_sys);
			ext_feedback <= fb;
			ext_status <= st;
			extended_ack_service_request <= 1'b1;
			@(posedge clk_sys);
			extended_ack_service_request <= 1'b0;
			wait_ev(1, 3, b);
			check({b, ack_send_ff, ack_pending_ff}, 3'b110);
			check({ack_feedback_ff, ack_status_ff}, {fb, st});
		end else begin
			reassembly_done <= 1'b1;
			wait_ev(0, 6, b);
			check(b, 0);
			@(posedge clk_sys);
			filter_done <= 1'b1;
			wait_ev(1, 4, b);
			check({b, ack_send_ff}, 2'b11);
			check({ack_status_ff, ack_fcs_ff}, {exp_map, fcs});
		end
		@(posedge clk_sys);
		{reassembly_done, filter_done, frame_ack_req} <= 3'b000;
	endtask : run_ack

	// Kind 0 is directed, 1 a broadcast destination, 2 a broadcast network.
	task automatic run_sw(input logic phy, input logic [1:0] mode, input logic lnk,
		input logic [1:0] kind);
		logic        hit;
		logic [7:0]  ch, ph;
		logic [15:0] ad, pn;
		ch = 8'($urandom);
		ph = 8'($urandom);
		ad = (kind == 2'h1) ? `FACS_BCAST_ADDR : {1'b0, 15'($urandom)};
		pn = (kind == 2'h2) ? `FACS_BCAST_PAN : {1'b0, 15'($urandom)};
		@(posedge clk_sys);
		{ack_mode, link_mode} <= {mode, lnk};
		{originator_addr, originator_pan} <= {ad, pn};
		{change_is_phy, new_channel, new_phy} <= {phy, ch, ph};
		channel_change_service <= 1'b1;
		@(posedge clk_sys);
		channel_change_service <= 1'b0;
		interval_end <= 1'b1;
		@(posedge clk_sys);
		interval_end <= 1'b0;
		wait_ev(2, 3, hit);
		check(hit, 1);
		wait_ev(4, 10, hit);
		if (kind != 2'h0) begin
			check(hit, 0);
			return;
		end
		check({hit, ack_request_bit_ff}, 2'b11);
		check({cmd_dest_ff, cmd_pan_ff}, {ad, pn});
		check({cmd_is_phy_ff, phy ? cmd_phy_ff : cmd_channel_ff}, {phy, phy ? ph : ch});
		if (mode == 2'h0) begin
			wait_ev(5, 270, hit);
			check({hit, cur_channel_ff, cur_phy_ff}, {1'b1, exp_ch, exp_ph});
		end else begin
			repeat ((mode == 2'h1) ? 8 : 19) @(posedge clk_sys);
			#1;
			check({cur_channel_ff, cur_phy_ff}, {phy ? exp_ch : ch, phy ? ph : exp_ph});
			repeat (REV + 10) @(posedge clk_sys);
			#1;
			if (lnk) begin
				exp_ch = phy ? exp_ch : ch;
				exp_ph = phy ? ph : exp_ph;
			end
			check({cur_channel_ff, cur_phy_ff}, {exp_ch, exp_ph});
		end
		repeat (REV + 10) @(posedge clk_sys);
	endtask : run_sw

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{extended_ack_enable, seq_start, frag_ok, frag_final, frame_ack_req, reassembly_done} = '0;
		{filter_enable, filter_done, interval_end, extended_ack_service_request} = '0;
		{channel_change_service, change_is_phy, guaranteed_slot_rx, hop_sequence_wanted} = '0;
		{frag_num, final_fcs, originator_addr, originator_pan, ext_feedback, ext_status} = '0;
		{new_channel, new_phy, ack_mode, link_mode, exp_ch, exp_ph} = '0;
		void'($urandom(18));
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		check({ack_send_ff, channel_switch_command_ff, frame_up_ff, cur_channel_ff}, 0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			{hop_sequence_wanted, guaranteed_slot_rx} <= 2'(i);
			repeat (2) @(posedge clk_sys);
			#1;
			check(guaranteed_slot_allocation_ff, code_of(i[0]));
			check(hop_sequence_request_ff, code_of(i[1]));
		end
		for (int r = 0; r < 3; r++) begin
			run_ack(1'b0);
			run_ack(1'b1);
		end
		run_sw(1'b0, 2'h0, 1'b0, 2'h0);
		run_sw(1'b0, 2'h1, 1'b0, 2'h0);
		run_sw(1'b1, 2'h1, 1'b0, 2'h1);
		run_sw(1'b0, 2'h1, 1'b1, 2'h2);
		for (int r = 0; r < 4; r++) begin
			run_sw(1'($urandom), 2'($urandom_range(1, 2)), 1'b1, 2'h0);
		end
		close_out();
	end

	initial begin
		#400000;
		miscompares++;
		close_out();
	end
endmodule : fragment_ack_channel_switch_tb_top
